// File: logic/cis_seq.sv
// Purpose: drives and supervises the motor shorting contactor
// Assumes: feedback inputs synchronous, high means contacts pulled in
// Notes: drive high energises the shorting contactor, opening it
`timescale 1ns/1ps
module cis_seq #(
    parameter int unsigned CLOSE_DELAY = cis_pkg::CLOSE_DELAY_CYC,
    parameter int unsigned FB_TIMEOUT = cis_pkg::FB_TIMEOUT_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_separate_contactor_option,
    input wire logic i_running_contactor_cmd,
    input wire logic i_running_contactor_feedback_in,
    input wire logic i_short_contactor_feedback_in,
    input wire logic i_fault_clear,
    output logic o_short_contactor_drive_out,
    output logic o_short_feedback_fault
);
    // refuse delays the counters cannot serve
    if (CLOSE_DELAY < 1 || FB_TIMEOUT < 1) begin : g_bad_delay
        $error("delays must be at least one cycle");
    end
    if (CLOSE_DELAY == 32'hFFFFFFFF) begin : g_big_delay
        $error("close delay leaves no room for the hold counter");
    end

    cis_pkg::cis_state_t st_q, st_d;
    logic drive_q, drive_d;
    logic fault_q, fault_d;
    logic run_fb_q;
    logic fb_load, fb_done, dl_load, dl_done, dl_busy, fb_stop;
    logic [31:0] quiet_q, quiet_d;

    // edge of running contactor feedback
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            run_fb_q <= 1'b0;
        end else begin
            run_fb_q <= i_running_contactor_feedback_in;
        end
    end

    cis_timer #(.WIDTH(32)) u_close_dly (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_load(dl_load),
        .i_count(CLOSE_DELAY),
        .i_stop(1'b0),
        .o_busy(dl_busy),
        .o_done(dl_done)
    );

    cis_timer #(.WIDTH(32)) u_fb_tmo (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_load(fb_load),
        .i_count(FB_TIMEOUT),
        .i_stop(fb_stop),
        .o_busy(),
        .o_done(fb_done)
    );

    always_comb begin
        st_d = st_q;
        drive_d = drive_q;
        dl_load = 1'b0;
        fb_load = 1'b0;
        // restart the delay on every change of running contactor
        if (run_fb_q != i_running_contactor_feedback_in) begin
            dl_load = 1'b1;
        end
        case (st_q)
            cis_pkg::CIS_IDLE: begin
                drive_d = 1'b0;
                if (i_separate_contactor_option && i_running_contactor_cmd
                        && i_running_contactor_feedback_in) begin
                    st_d = cis_pkg::CIS_OPEN;
                    drive_d = 1'b1;
                    fb_load = 1'b1;
                end
            end
            cis_pkg::CIS_OPEN: begin
                if (!i_separate_contactor_option
                        || !i_running_contactor_feedback_in) begin
                    st_d = cis_pkg::CIS_HOLD;
                end
            end
            cis_pkg::CIS_HOLD: begin
                // keep open until running contactor settled open
                if (!i_running_contactor_feedback_in && !run_fb_q
                        && dl_done) begin
                    st_d = cis_pkg::CIS_IDLE;
                    drive_d = 1'b0;
                    fb_load = i_separate_contactor_option;
                end else if (i_running_contactor_feedback_in
                        && i_separate_contactor_option) begin
                    st_d = cis_pkg::CIS_OPEN;
                end
            end
            default: begin
                st_d = cis_pkg::CIS_HOLD;
                drive_d = 1'b1;
            end
        endcase
    end

    // feedback must follow the drive before the timeout ends
    assign fb_stop = (i_short_contactor_feedback_in == drive_q) && !fb_load;

    always_comb begin
        fault_d = fault_q;
        if (i_fault_clear) begin
            fault_d = 1'b0;
        end
        if (fb_done && i_separate_contactor_option
                && i_short_contactor_feedback_in != drive_q) begin
            fault_d = 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_q <= cis_pkg::CIS_IDLE;
            drive_q <= cis_pkg::RST_DRIVE;
            fault_q <= cis_pkg::RST_FAULT;
        end else begin
            st_q <= st_d;
            drive_q <= drive_d;
            fault_q <= fault_d;
        end
    end

    // outputs only go high with the option on
    assign o_short_contactor_drive_out = drive_q;
    assign o_short_feedback_fault = fault_q;

    // cycles since the running contactor last changed, for the checks
    always_comb begin
        quiet_d = quiet_q;
        if (dl_load) begin
            quiet_d = '0;
        end else if (quiet_q <= CLOSE_DELAY) begin
            quiet_d = quiet_q + 32'h00000001;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            quiet_q <= '0;
        end else begin
            quiet_q <= quiet_d;
        end
    end

    sequence s_settled_open;
        !run_fb_q && !dl_busy;
    endsequence

    sequence s_open_req;
        st_q == cis_pkg::CIS_IDLE && i_separate_contactor_option
            && i_running_contactor_cmd && i_running_contactor_feedback_in;
    endsequence

    sequence s_fb_lost;
        fb_done && i_separate_contactor_option
            && i_short_contactor_feedback_in != drive_q;
    endsequence

    close_guard_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        $fell(drive_q) |-> s_settled_open)
        else $error("shorting contactor closed too early");

    close_delay_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        $fell(drive_q) |-> quiet_q > CLOSE_DELAY)
        else $error("shorting contactor closed before the delay");

    hold_open_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        (drive_q && i_running_contactor_feedback_in) |=> drive_q)
        else $error("shorting contactor closed while running engaged");

    idle_closed_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        (st_q == cis_pkg::CIS_IDLE) |-> !drive_q)
        else $error("drive high in idle");

    open_follow_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        s_open_req |=> drive_q)
        else $error("shorting contactor not opened");

    fault_set_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        s_fb_lost |=> fault_q)
        else $error("feedback fault not raised");

    fault_keep_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        (fault_q && !i_fault_clear) |=> fault_q)
        else $error("feedback fault dropped without clear");

    fault_cause_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        $rose(fault_q) |-> $past(fb_done))
        else $error("fault without timeout");

    opt_off_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        (!i_separate_contactor_option && !drive_q) |=> !drive_q)
        else $error("drive moved with option off");

    no_fault_off_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        (!i_separate_contactor_option && !fault_q) |=> !fault_q)
        else $error("fault raised with option off");
endmodule : cis_seq

// File: logic/cis_pkg.sv
// Purpose: constants for the shorting contactor sequencer
// Assumes: 250 MHz system clock
// Notes: no registers reachable by software
// What this block does
// - With the separate-contactor option on, the shorting drive output and feedback input are in use.
// - Whenever the running contactor is actuated with the option on, the shorting contactor is actuated too.
// - Shorting-contactor feedback not following a drive change within the timeout while the option is on raises the feedback fault.
// - Once the running contactor is commanded and seen pulled in with the option on, the shorting contactor is opened.
// - Return of the normally closed shorting contactor to closed waits 300 ms after the running contactor changes.
// - The shorting contactor never closes while the running contactor is not fully open.
package cis_pkg;
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned CLOSE_DELAY_MS = 300;
    localparam int unsigned CLOSE_DELAY_CYC = CLOSE_DELAY_MS * 1000 * CLK_MHZ;
    localparam int unsigned FB_TIMEOUT_US = 100;
    localparam int unsigned FB_TIMEOUT_CYC = FB_TIMEOUT_US * CLK_MHZ;
    localparam logic RST_DRIVE = 1'b0;
    localparam logic RST_FAULT = 1'b0;
    typedef enum logic [1:0] {
        CIS_IDLE,
        CIS_OPEN,
        CIS_HOLD
    } cis_state_t;
endpackage : cis_pkg

// File: logic/cis_timer.sv
// Purpose: loadable down counter with done pulse
// Assumes: synchronous inputs
// Notes: done is a one-cycle pulse once the count reaches one
`timescale 1ns/1ps
module cis_timer #(
    parameter int unsigned WIDTH = 32
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_load,
    input wire logic [WIDTH-1:0] i_count,
    input wire logic i_stop,
    output logic o_busy,
    output logic o_done
);
    logic [WIDTH-1:0] cnt_q, cnt_d;
    logic busy_q, busy_d;
    logic done_q, done_d;

    always_comb begin
        cnt_d = cnt_q;
        busy_d = busy_q;
        done_d = 1'b0;
        if (i_stop) begin
            busy_d = 1'b0;
        end else if (i_load) begin
            cnt_d = i_count;
            busy_d = 1'b1;
        end else if (busy_q) begin
            if (cnt_q <= WIDTH'(1)) begin
                busy_d = 1'b0;
                done_d = 1'b1;
            end else begin
                cnt_d = cnt_q - WIDTH'(1);
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_q <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

    assign o_busy = busy_q;
    assign o_done = done_q;
endmodule : cis_timer

// File: tb/cis_contactors.sv
// Purpose: running and shorting contactor model with aux feedback
// Assumes: feedback high means contacts pulled in
// Notes: broken shorting contactor never reports action
`timescale 1ns/1ps
module cis_contactors (
    input wire logic i_sys_clk,
    input wire logic i_run_cmd,
    input wire logic i_drive,
    input wire logic i_broken,
    input wire logic [2:0] i_delay,
    output logic o_run_fb,
    output logic o_short_fb
);
    logic [7:0] run_q = 8'h00;
    logic [7:0] short_q = 8'h00;
    // mechanical pull-in lag on both contactors
    always @(posedge i_sys_clk) begin
        run_q <= {run_q[6:0], i_run_cmd};
        short_q <= {short_q[6:0], i_drive};
    end
    assign o_run_fb = run_q[2];
    assign o_short_fb = i_broken ? 1'b0 : short_q[i_delay];
endmodule : cis_contactors

// File: tb/tb_top.sv
// Purpose: self-checking bench for the shorting contactor sequencer
// Assumes: short delays of 20 and 10 cycles
// Notes: random option, broken feedback and lag, seed 16
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic opt = 1'b0;
    logic cmd = 1'b0;
    logic clr = 1'b0;
    logic brk = 1'b0;
    logic hung = 1'b0;
    logic [2:0] dly = 3'h1;
    logic run_fb, sh_fb, drv, flt;
    int n_fail = 0;
    int samples_checked = 0;
    int seed = 16;
    always #2 clk = ~clk;
    cis_seq #(.CLOSE_DELAY(20), .FB_TIMEOUT(10)) cis_seq_i (
        .i_sys_clk(clk), .i_rst_b(rst_b),
        .i_separate_contactor_option(opt), .i_running_contactor_cmd(cmd),
        .i_running_contactor_feedback_in(run_fb),
        .i_short_contactor_feedback_in(sh_fb), .i_fault_clear(clr),
        .o_short_contactor_drive_out(drv), .o_short_feedback_fault(flt));
    cis_contactors cis_contactors_i (.i_sys_clk(clk), .i_run_cmd(cmd),
        .i_drive(drv), .i_broken(brk), .i_delay(dly), .o_run_fb(run_fb),
        .o_short_fb(sh_fb));
    function automatic logic fault_exp(input logic o, input logic b);
        return o & b;
    endfunction : fault_exp
    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task chk(input logic got, input logic exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask : chk
    task stop_test;
        $display("checked %0d, failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : stop_test
    task run_cycle(input logic o, input logic b);
        int k;
        if (hung === 1'b1) return;
        opt <= o;
        brk <= b;
        dly <= 3'(1 + $unsigned($random(seed)) % 5);
        cmd <= 1'b1;
        cyc(6);
        #1 chk(drv, o, "drive after pull-in");
        cyc(7);
        #1 chk(flt, 1'b0, "fault before timeout");
        cyc(7);
        #1 chk(flt, fault_exp(o, b), "feedback fault");
        cyc(1);
        cmd <= 1'b0;
        cyc(22);
        #1 chk(drv, o, "early close");
        for (k = 0; k < 12 && drv !== 1'b0; k++) begin
            cyc(1);
            #1;
        end
        chk(drv, 1'b0, "delayed close");
        if (drv !== 1'b0) hung = 1'b1;
        cyc(1);
        clr <= 1'b1;
        cyc(1);
        clr <= 1'b0;
        cyc(2);
        #1 chk(flt, 1'b0, "fault clear");
        cyc(1);
    endtask : run_cycle
    initial begin
        cyc(16);
        rst_b <= 1'b1;
        cyc(2);
        run_cycle(1'b0, 1'b0);
        run_cycle(1'b0, 1'b1);
        run_cycle(1'b1, 1'b0);
        run_cycle(1'b1, 1'b1);
        repeat (8) run_cycle(1'($random(seed)), 1'($random(seed)));
        stop_test();
    end
endmodule : tb_top
